// [fcnsr_fuse_mem.sv]
// Sixteen-bit one-time-programmable fuse array with a timed burn of one bit at a time.
// Assumes the caller only pulses prog_go while the array is idle and programming is enabled.
`timescale 1ns/10ps
`default_nettype none
module fcnsr_fuse_mem (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic prog_go,
   input wire logic [3:0] prog_idx,
   output logic [15:0] image_reg,
   output logic busy_reg
);
   fcnsr_pkg::fcnsr_fuse_state_t state_reg, state_next;
   logic [15:0] image_next;
   logic [15:0] count_reg, count_next;
   logic [3:0] idx_reg, idx_next;
   logic busy_next;

   always_comb begin
      state_next = state_reg;
      image_next = image_reg;
      count_next = count_reg;
      idx_next = idx_reg;
      unique case (state_reg)
         fcnsr_pkg::FCNSR_FUSE_IDLE: begin
            if (prog_go) begin
               state_next = fcnsr_pkg::FCNSR_FUSE_BURN;
               idx_next = prog_idx;
               count_next = 16'(fcnsr_pkg::NV_PROG_CYCLES - 1);
            end
         end
         fcnsr_pkg::FCNSR_FUSE_BURN: begin
            if (count_reg == 16'h0000) begin
               image_next[idx_reg] = 1'b1;
               state_next = fcnsr_pkg::FCNSR_FUSE_IDLE;
            end else begin
               count_next = count_reg - 16'h0001;
            end
         end
      endcase
      busy_next = (state_next == fcnsr_pkg::FCNSR_FUSE_BURN);
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= fcnsr_pkg::FCNSR_FUSE_IDLE;
         image_reg <= fcnsr_pkg::FUSE_RESET_IMAGE;
         count_reg <= 16'h0000;
         idx_reg <= 4'h0;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         image_reg <= image_next;
         count_reg <= count_next;
         idx_reg <= idx_next;
         busy_reg <= busy_next;
      end
   end
endmodule
`default_nettype wire

// [fcnsr_pkg.sv]
// Constants, register map and carrier types for the calibration, fuse and self-test register group.
// Assumes a 100 MHz core clock shared by the serial register port and the calibration engine.
`default_nettype none
package fcnsr_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int NV_PROG_TIME_NS = 10000;
   localparam int NV_PROG_CYCLES = (NV_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] ADDR_CAL_STROBE = 5'h04;
   localparam logic [4:0] ADDR_CAL_STATUS = 5'h08;
   localparam logic [4:0] ADDR_CAL_COUNT = 5'h09;
   localparam logic [4:0] ADDR_NV_IMAGE = 5'h0a;
   localparam logic [4:0] ADDR_NV_ENABLE = 5'h0b;
   localparam logic [4:0] ADDR_NV_ADDRESS = 5'h0c;
   localparam logic [4:0] ADDR_NV_STROBE = 5'h0d;
   localparam logic [4:0] ADDR_ST_ENABLE = 5'h0e;
   localparam logic [4:0] ADDR_ST_RESULT = 5'h0f;
   localparam int STAT_CAL_BUSY_BIT = 4;
   localparam int STAT_NV_BUSY_BIT = 5;
   localparam int ST_BUSY_BIT = 16;
   localparam int IMG_FINE_LSB = 0;
   localparam int IMG_COARSE_LO_LSB = 4;
   localparam int IMG_GAIN_BIT = 7;
   localparam int IMG_BYPASS_BIT = 8;
   localparam int IMG_OPAMP_LSB = 9;
   localparam int IMG_DRVR_LSB = 11;
   localparam int IMG_VALID_BIT = 13;
   localparam int IMG_COARSE_HI_BIT = 14;
   localparam logic [3:0] FINE_CODE_MAX = 4'hb;
   localparam int ADJ_UNIT_SHIFT = 10;
   localparam int CAL_CODE_SHIFT = 12;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_SEED = 16'hffff;
   localparam logic [15:0] FUSE_RESET_IMAGE = 16'h0000;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [23:0] wdata;
   } fcnsr_req_t;

   typedef struct packed {
      logic done;
      logic [23:0] count;
   } fcnsr_meas_t;

   typedef struct packed {
      logic valid;
      logic [3:0] fine;
      logic [3:0] coarse;
      logic gain;
      logic bypass;
      logic [1:0] opamp;
      logic [1:0] drvr;
   } fcnsr_nv_t;

   typedef enum {
      FCNSR_IDLE,
      FCNSR_CAL,
      FCNSR_SELFTEST
   } fcnsr_state_t;

   typedef enum {
      FCNSR_FUSE_IDLE,
      FCNSR_FUSE_BURN
   } fcnsr_fuse_state_t;
endpackage
`default_nettype wire

// [fcnsr_rc_model.sv]
// Behavioural RC measurement engine that answers each start pulse with one counter result.
// Assumes start is a one-cycle pulse on the shared clock; the bench sets delay and result.
`timescale 1ns/10ps
`default_nettype none
module fcnsr_rc_model (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic start,
   input wire logic [7:0] delay,
   input wire logic [23:0] result,
   output wire fcnsr_pkg::fcnsr_meas_t meas
);
   logic [7:0] left_reg;
   logic run_reg;
   logic done_reg;
   logic [23:0] last_reg;
   // Outside the done cycle the count shows the inverse of the last result, never a held value.
   assign meas = {done_reg, done_reg ? last_reg : ~last_reg};
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         left_reg <= 8'h00;
         run_reg <= 1'b0;
         done_reg <= 1'b0;
         last_reg <= 24'h000000;
      end else begin
         done_reg <= 1'b0;
         if (start) begin
            run_reg <= 1'b1;
            left_reg <= delay;
         end else if (run_reg && left_reg == 8'h00) begin
            run_reg <= 1'b0;
            done_reg <= 1'b1;
            last_reg <= result;
         end else if (run_reg) begin
            left_reg <= left_reg - 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// [fcnsr_regs.sv]
// Calibration status, fuse programming and RC self-test registers behind the serial register port.
// Assumes the serial port shell and the RC measurement engine run on the same clock as this block.
`timescale 1ns/10ps
`default_nettype none
module fcnsr_regs (
   input wire logic clock,
   input wire logic rst_b,
   input wire fcnsr_pkg::fcnsr_req_t req,
   input wire fcnsr_pkg::fcnsr_meas_t meas,
   input wire logic [8:0] meas_adj,
   output logic [23:0] rdata_reg,
   output logic cal_start_reg,
   output logic [3:0] fine_code_reg,
   output logic cfg_bit0_force_reg,
   output fcnsr_pkg::fcnsr_nv_t nv_reg
);
   fcnsr_pkg::fcnsr_state_t state_reg, state_next;
   logic [23:0] rdata_next;
   logic cal_start_next;
   logic [3:0] fine_code_next;
   logic cfg_bit0_force_next;
   fcnsr_pkg::fcnsr_nv_t nv_next;
   logic [23:0] count_reg, count_next;
   logic nv_enable_bit_reg, nv_enable_bit_next;
   logic [3:0] nv_addr_reg, nv_addr_next;
   logic self_test_mode_on_reg, self_test_mode_on_next;
   logic [15:0] self_test_signature_reg, self_test_signature_next;
   logic [15:0] image;
   logic nv_program_active;
   logic prog_go;
   logic cal_busy;
   logic self_test_running;
   logic signed [25:0] adjusted;
   logic [13:0] code_idx;

   fcnsr_fuse_mem u_fuse (
      .clock(clock),
      .rst_b(rst_b),
      .prog_go(prog_go),
      .prog_idx(nv_addr_reg),
      .image_reg(image),
      .busy_reg(nv_program_active)
   );

   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [23:0] data);
      logic [15:0] c;
      c = crc;
      for (int i = 23; i >= 0; i--) begin
         c = (c[15] ^ data[i]) ? ((c << 1) ^ fcnsr_pkg::CRC_POLY) : (c << 1);
      end
      return c;
   endfunction

   assign cal_busy = (state_reg == fcnsr_pkg::FCNSR_CAL);
   assign self_test_running = (state_reg == fcnsr_pkg::FCNSR_SELFTEST);
   // Fuse strobe is honoured only with programming enabled and no burn under way.
   assign prog_go = req.wr && (req.addr == fcnsr_pkg::ADDR_NV_STROBE) && nv_enable_bit_reg
                    && !nv_program_active;
   // Correction is in 1.024 ns units, scaled to picoseconds before decoding.
   assign adjusted = $signed({2'b00, meas.count})
                     + ($signed({{17{meas_adj[8]}}, meas_adj}) <<< fcnsr_pkg::ADJ_UNIT_SHIFT);
   assign code_idx = adjusted[25:fcnsr_pkg::CAL_CODE_SHIFT];

   always_comb begin
      state_next = state_reg;
      cal_start_next = 1'b0;
      count_next = count_reg;
      fine_code_next = fine_code_reg;
      self_test_signature_next = self_test_signature_reg;
      unique case (state_reg)
         fcnsr_pkg::FCNSR_IDLE: begin
            if (req.wr && req.addr == fcnsr_pkg::ADDR_CAL_STROBE) begin
               cal_start_next = 1'b1;
               if (self_test_mode_on_reg) begin
                  state_next = fcnsr_pkg::FCNSR_SELFTEST;
                  self_test_signature_next = fcnsr_pkg::CRC_SEED;
               end else begin
                  state_next = fcnsr_pkg::FCNSR_CAL;
               end
            end
         end
         fcnsr_pkg::FCNSR_CAL: begin
            if (meas.done) begin
               state_next = fcnsr_pkg::FCNSR_IDLE;
               count_next = meas.count;
               if (adjusted < 0) begin
                  fine_code_next = 4'h0;
               end else if (code_idx > 14'(fcnsr_pkg::FINE_CODE_MAX)) begin
                  fine_code_next = fcnsr_pkg::FINE_CODE_MAX;
               end else begin
                  fine_code_next = code_idx[3:0];
               end
            end
         end
         fcnsr_pkg::FCNSR_SELFTEST: begin
            if (meas.done) begin
               state_next = fcnsr_pkg::FCNSR_IDLE;
               self_test_signature_next = crc_step(self_test_signature_reg, meas.count);
            end
         end
      endcase
   end

   always_comb begin
      nv_enable_bit_next = nv_enable_bit_reg;
      nv_addr_next = nv_addr_reg;
      self_test_mode_on_next = self_test_mode_on_reg;
      rdata_next = rdata_reg;
      if (req.wr) begin
         unique case (req.addr)
            fcnsr_pkg::ADDR_NV_ENABLE: nv_enable_bit_next = req.wdata[0];
            fcnsr_pkg::ADDR_NV_ADDRESS: nv_addr_next = req.wdata[3:0];
            fcnsr_pkg::ADDR_ST_ENABLE: self_test_mode_on_next = req.wdata[0];
            default: nv_addr_next = nv_addr_reg;
         endcase
      end
      if (req.rd) begin
         unique case (req.addr)
            fcnsr_pkg::ADDR_CAL_STATUS: begin
               rdata_next = 24'h000000;
               rdata_next[3:0] = fine_code_reg;
               rdata_next[fcnsr_pkg::STAT_CAL_BUSY_BIT] = cal_busy;
               rdata_next[fcnsr_pkg::STAT_NV_BUSY_BIT] = nv_program_active;
            end
            fcnsr_pkg::ADDR_CAL_COUNT: rdata_next = count_reg;
            fcnsr_pkg::ADDR_NV_IMAGE: rdata_next = {8'h00, image};
            fcnsr_pkg::ADDR_NV_ENABLE: rdata_next = {23'h000000, nv_enable_bit_reg};
            fcnsr_pkg::ADDR_NV_ADDRESS: rdata_next = {20'h00000, nv_addr_reg};
            fcnsr_pkg::ADDR_ST_ENABLE: rdata_next = {23'h000000, self_test_mode_on_reg};
            fcnsr_pkg::ADDR_ST_RESULT: begin
               rdata_next = {8'h00, self_test_signature_reg};
               rdata_next[fcnsr_pkg::ST_BUSY_BIT] = self_test_running;
            end
            default: rdata_next = 24'h000000;
         endcase
      end
   end

   always_comb begin
      nv_next.fine = image[fcnsr_pkg::IMG_FINE_LSB +: 4];
      nv_next.coarse = {image[fcnsr_pkg::IMG_COARSE_HI_BIT], image[fcnsr_pkg::IMG_COARSE_LO_LSB +: 3]};
      nv_next.gain = image[fcnsr_pkg::IMG_GAIN_BIT];
      nv_next.bypass = image[fcnsr_pkg::IMG_BYPASS_BIT];
      nv_next.opamp = image[fcnsr_pkg::IMG_OPAMP_LSB +: 2];
      nv_next.drvr = image[fcnsr_pkg::IMG_DRVR_LSB +: 2];
      nv_next.valid = image[fcnsr_pkg::IMG_VALID_BIT];
      cfg_bit0_force_next = !image[fcnsr_pkg::IMG_VALID_BIT];
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= fcnsr_pkg::FCNSR_IDLE;
         rdata_reg <= 24'h000000;
         cal_start_reg <= 1'b0;
         fine_code_reg <= 4'h0;
         cfg_bit0_force_reg <= 1'b1;
         nv_reg <= '0;
         count_reg <= 24'h000000;
         nv_enable_bit_reg <= 1'b0;
         nv_addr_reg <= 4'h0;
         self_test_mode_on_reg <= 1'b0;
         self_test_signature_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         rdata_reg <= rdata_next;
         cal_start_reg <= cal_start_next;
         fine_code_reg <= fine_code_next;
         cfg_bit0_force_reg <= cfg_bit0_force_next;
         nv_reg <= nv_next;
         count_reg <= count_next;
         nv_enable_bit_reg <= nv_enable_bit_next;
         nv_addr_reg <= nv_addr_next;
         self_test_mode_on_reg <= self_test_mode_on_next;
         self_test_signature_reg <= self_test_signature_next;
      end
   end

   AST_FINE_RANGE: assert property (@(posedge clock) disable iff (!rst_b)
      fine_code_reg <= fcnsr_pkg::FINE_CODE_MAX) else $error("Fine code out of range.");
   AST_FINE_ONLY_AFTER_CAL: assert property (@(posedge clock) disable iff (!rst_b)
      !($past(cal_busy) && $past(meas.done)) |-> $stable(fine_code_reg)) else $error("Fine code moved without a run.");
   AST_CAL_START: assert property (@(posedge clock) disable iff (!rst_b)
      (req.wr && req.addr == fcnsr_pkg::ADDR_CAL_STROBE && state_reg == fcnsr_pkg::FCNSR_IDLE
       && !self_test_mode_on_reg) |=> (cal_busy && cal_start_reg)) else $error("Strobe did not start calibration.");
   AST_CAL_BUSY_END: assert property (@(posedge clock) disable iff (!rst_b)
      (cal_busy && meas.done) |=> !cal_busy) else $error("Calibration busy not cleared.");
   AST_CAL_BUSY_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
      (cal_busy && !meas.done) |=> cal_busy) else $error("Calibration busy dropped early.");
   AST_COUNT_CAPTURE: assert property (@(posedge clock) disable iff (!rst_b)
      (cal_busy && meas.done) |=> count_reg == $past(meas.count)) else $error("Raw count not captured.");
   AST_NV_GATED: assert property (@(posedge clock) disable iff (!rst_b)
      (req.wr && req.addr == fcnsr_pkg::ADDR_NV_STROBE && !nv_enable_bit_reg && !nv_program_active)
      |=> !nv_program_active) else $error("Fuse write without enable.");
   AST_NV_BUSY: assert property (@(posedge clock) disable iff (!rst_b)
      prog_go |=> nv_program_active [*8]) else $error("Fuse busy not held.");
   AST_ST_START: assert property (@(posedge clock) disable iff (!rst_b)
      (req.wr && req.addr == fcnsr_pkg::ADDR_CAL_STROBE && state_reg == fcnsr_pkg::FCNSR_IDLE
       && self_test_mode_on_reg) |=> (self_test_running && !cal_busy)) else $error("Self-test not started.");
   AST_ST_DONE: assert property (@(posedge clock) disable iff (!rst_b)
      (self_test_running && meas.done) |=> (!self_test_running
       && self_test_signature_reg == crc_step($past(self_test_signature_reg), $past(meas.count))))
      else $error("Self-test result wrong.");
   AST_OVERRIDE: assert property (@(posedge clock) disable iff (!rst_b)
      !image[fcnsr_pkg::IMG_VALID_BIT] |=> cfg_bit0_force_reg) else $error("Override missing.");
endmodule
`default_nettype wire

// [fcnsr_tb.sv]
// Self-checking bench for the calibration, fuse and self-test register group.
// Assumes the RC engine model beside it and a 100 MHz clock with active-low reset.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clock;
   logic rst_b;
   fcnsr_pkg::fcnsr_req_t req;
   fcnsr_pkg::fcnsr_meas_t meas;
   fcnsr_pkg::fcnsr_nv_t nv_reg;
   logic [8:0] meas_adj;
   logic [7:0] delay;
   logic [23:0] result;
   logic [23:0] rdata_reg;
   logic [23:0] rd;
   logic [3:0] fine_code_reg;
   logic cal_start_reg;
   logic cfg_bit0_force_reg;
   int n_errors;
   int checks_done;
   fcnsr_regs fcnsr_regs_i (.clock(clock), .rst_b(rst_b), .req(req), .meas(meas), .meas_adj(meas_adj),
      .rdata_reg(rdata_reg), .cal_start_reg(cal_start_reg), .fine_code_reg(fine_code_reg),
      .cfg_bit0_force_reg(cfg_bit0_force_reg), .nv_reg(nv_reg));
   fcnsr_rc_model fcnsr_rc_model_i (.clock(clock), .rst_b(rst_b), .start(cal_start_reg), .delay(delay),
      .result(result), .meas(meas));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic complete_run();
      if (n_errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick();
      @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [4:0] a, input logic [23:0] d);
      tick();
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      tick();
      req.wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [4:0] a, output logic [23:0] d);
      tick();
      req.rd = 1'b1;
      req.addr = a;
      tick();
      req.rd = 1'b0;
      tick();
      d = rdata_reg;
   endtask
   task automatic expect_reg(input logic [4:0] a, input logic [23:0] exp);
      rd_reg(a, rd);
      check(rd, exp);
   endtask
   task automatic wait_idle(input logic [4:0] a, input int b);
      for (int i = 0; i < 800; i++) begin
         rd_reg(a, rd);
         if (rd[b] === 1'b0) return;
      end
      n_errors++;
      complete_run();
   endtask
   function automatic logic [15:0] crc_of(input logic [23:0] v);
      logic [15:0] c;
      c = 16'hffff;
      for (int i = 23; i >= 0; i--) begin
         c = (c[15] ^ v[i]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
      end
      return c;
   endfunction
   task automatic test_reset();
      check({23'h0, cfg_bit0_force_reg}, 24'h000001);
      expect_reg(fcnsr_pkg::ADDR_ST_ENABLE, 24'h000000);
      expect_reg(fcnsr_pkg::ADDR_ST_RESULT, 24'h000000);
      expect_reg(5'h10, 24'h000000);
      wr(fcnsr_pkg::ADDR_CAL_STATUS, 24'hffffff);
      expect_reg(fcnsr_pkg::ADDR_CAL_STATUS, 24'h000000);
      wr(fcnsr_pkg::ADDR_NV_ADDRESS, 24'h00000d);
      wr(fcnsr_pkg::ADDR_NV_STROBE, 24'h000001);
      expect_reg(fcnsr_pkg::ADDR_CAL_STATUS, 24'h000000);
      expect_reg(fcnsr_pkg::ADDR_NV_IMAGE, 24'h000000);
      expect_reg(fcnsr_pkg::ADDR_NV_STROBE, 24'h000000);
   endtask
   task automatic run_cal(input logic [23:0] c, input logic [8:0] adj, input logic [3:0] f);
      result = c;
      meas_adj = adj;
      wr(fcnsr_pkg::ADDR_CAL_STROBE, 24'h00a5a5);
      check({23'h0, cal_start_reg}, 24'h000001);
      rd_reg(fcnsr_pkg::ADDR_CAL_STATUS, rd);
      check({23'h0, rd[4]}, 24'h000001);
      wr(fcnsr_pkg::ADDR_CAL_STROBE, 24'h000000);
      check({23'h0, cal_start_reg}, 24'h000000);
      wait_idle(fcnsr_pkg::ADDR_CAL_STATUS, 4);
      check({20'h0, rd[3:0]}, {20'h0, f});
      check({20'h0, fine_code_reg}, {20'h0, f});
      expect_reg(fcnsr_pkg::ADDR_CAL_COUNT, c);
   endtask
   task automatic test_cal();
      run_cal(24'h005064, 9'h000, 4'h5);
      run_cal(24'h005064, 9'h1ff, 4'h4);
      run_cal(24'hffffff, 9'h000, 4'hb);
      run_cal(24'h000100, 9'h100, 4'h0);
   endtask
   task automatic fuse_bit(input logic [3:0] idx);
      wr(fcnsr_pkg::ADDR_NV_ADDRESS, {20'h0, idx});
      wr(fcnsr_pkg::ADDR_NV_STROBE, 24'h000000);
      rd_reg(fcnsr_pkg::ADDR_CAL_STATUS, rd);
      check({23'h0, rd[5]}, 24'h000001);
      wait_idle(fcnsr_pkg::ADDR_CAL_STATUS, 5);
   endtask
   task automatic test_fuse();
      logic [3:0] bits [5] = '{4'h0, 4'h4, 4'h7, 4'h8, 4'h9};
      wr(fcnsr_pkg::ADDR_NV_ENABLE, 24'h000001);
      expect_reg(fcnsr_pkg::ADDR_NV_ENABLE, 24'h000001);
      foreach (bits[i]) begin
         fuse_bit(bits[i]);
      end
      check({23'h0, cfg_bit0_force_reg}, 24'h000001);
      fuse_bit(4'hd);
      fuse_bit(4'he);
      expect_reg(fcnsr_pkg::ADDR_NV_IMAGE, 24'h006391);
      check({9'h0, nv_reg}, {9'h0, 1'b1, 4'h1, 4'h9, 1'b1, 1'b1, 2'b01, 2'b00});
      check({23'h0, cfg_bit0_force_reg}, 24'h000000);
   endtask
   task automatic test_selftest();
      wr(fcnsr_pkg::ADDR_ST_ENABLE, 24'h000001);
      expect_reg(fcnsr_pkg::ADDR_ST_ENABLE, 24'h000001);
      result = 24'h123456;
      delay = 8'd30;
      wr(fcnsr_pkg::ADDR_CAL_STROBE, 24'h000000);
      check({23'h0, cal_start_reg}, 24'h000001);
      rd_reg(fcnsr_pkg::ADDR_ST_RESULT, rd);
      check({23'h0, rd[16]}, 24'h000001);
      wait_idle(fcnsr_pkg::ADDR_ST_RESULT, 16);
      check(rd, {8'h0, crc_of(24'h123456)});
      check({20'h0, fine_code_reg}, 24'h000000);
      wr(fcnsr_pkg::ADDR_ST_ENABLE, 24'h000000);
      expect_reg(fcnsr_pkg::ADDR_ST_ENABLE, 24'h000000);
   endtask
   initial begin
      rst_b = 1'b0;
      req = '0;
      meas_adj = 9'h000;
      delay = 8'd20;
      result = 24'h000000;
      n_errors = 0;
      checks_done = 0;
      repeat (12) @(posedge clock);
      #1;
      rst_b = 1'b1;
      test_reset();
      test_cal();
      test_fuse();
      test_selftest();
      complete_run();
   end
endmodule
`default_nettype wire
